// *** common/rsc_params.svh ***
// Constants of the reset source controller: register indices, bit positions,
// timing figures and reset values.
// Assumes a 250 MHz aclk and an AXI4-Lite slave port with 12-bit byte addresses.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index
`define RSC_IDX_PWR   8'h87
`define RSC_IDX_CAUSE 8'hEF
`define RSC_IDX_STAT  8'h80
`define RSC_AW        12

// ==========================================================================
// power_mode_control fields
`define RSC_B_IDLE  0
`define RSC_B_STOP  1
`define RSC_B_GF_LO 2
`define RSC_B_GF_HI 7

// ==========================================================================
// reset_cause_byte fields
`define RSC_B_PIN  0
`define RSC_B_POR  1
`define RSC_B_MCD  2
`define RSC_B_WDT  3
`define RSC_B_SW   4
`define RSC_B_CMP  5
`define RSC_B_MEM  6
`define RSC_NSRC   7

// ==========================================================================
// Timing
`define RSC_CLK_PERIOD_NS  4
`define RSC_POR_DELAY_NS   300000
`define RSC_MCD_TIMEOUT_NS 100000
`define RSC_CNT_W          17
`define RSC_PULSE_CYC      17'h0_0010
`define RSC_WDT_DIV        4'hC

// ==========================================================================
// Reset values and bus answers
`define RSC_PORT_RST  8'hFF
`define RSC_FETCH_RST 16'h0000
`define RSC_RESP_OK   2'h0
`define RSC_RESP_ERR  2'h2

`endif

// *** common/rsc_pkg.sv ***
// Types of the reset source controller: sequencer states and state records.
// Assumes rsc_params.svh is on the include path.
`include "rsc_params.svh"

package rsc_pkg;

  // ========================================================================
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    RSC_POR   = 6'h01, // Power-up, pin driven low
    RSC_VMON  = 6'h02, // Supply monitor hold, pin driven low
    RSC_REL   = 6'h04, // Delay with pin driven, then pin released and rise wait
    RSC_HOLD  = 6'h08, // Held while a level source is active
    RSC_PULSE = 6'h10, // Fixed pulse for event sources
    RSC_RUN   = 6'h20  // Core running
  } rsc_state_t;

  // ========================================================================
  // State of the controller apart from the missing clock detector
  typedef struct packed {
    rsc_state_t                st;
    logic [`RSC_CNT_W-1:0]     cnt;
    logic [`RSC_NSRC-1:0]      flags;
    logic [`RSC_NSRC-1:0]      src;
    logic                      vmon_en;
    logic                      mcd_en;
    logic                      cmp_en;
    logic [5:0]                gf;
    logic                      idle;
    logic                      stop;
    logic                      pin1;
    logic                      pin2;
    logic                      sup1;
    logic                      sup2;
    logic                      cmp1;
    logic                      cmp2;
    logic [3:0]                div;
    logic                      wdt_tick;
    logic                      wdt_restart;
    logic                      core_reset;
    logic                      core_start;
    logic                      core_clk_en;
    logic                      osc_enable;
    logic                      osc_internal;
    logic [15:0]               fetch_addr;
    logic                      pin_drive;
    logic                      pin_oe_n;
    logic [7:0]                port_latch;
    logic                      port_open_drain;
    logic                      port_pullup;
    logic                      aw_ok;
    logic [`RSC_AW-1:0]        aw_a;
    logic                      w_ok;
    logic [7:0]                w_d;
    logic                      w_s;
    logic                      awready;
    logic                      wready;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [7:0]                rdata;
    logic [1:0]                rresp;
  } rsc_regs_t;

  // ========================================================================
  // State of the missing clock detector
  typedef struct packed {
    logic                      s1;
    logic                      s2;
    logic                      s3;
    logic [`RSC_CNT_W-1:0]     cnt;
    logic                      timeout;
  } rsc_mcd_regs_t;

endpackage

// *** rtl/rsc_mcd.sv ***
// Missing clock detector: watches a clock for edges and pulses on a timeout.
// Assumes the watched clock is well below half the aclk rate.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"

module rsc_mcd #(
  parameter logic [`RSC_CNT_W-1:0] TIMEOUT_CYC = `RSC_CNT_W'(`RSC_MCD_TIMEOUT_NS / `RSC_CLK_PERIOD_NS)
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clk_en,
  input  wire logic enable,
  input  wire logic system_clock_mon,
  output logic      timeout
);

  rsc_pkg::rsc_mcd_regs_t r;
  rsc_pkg::rsc_mcd_regs_t next_r;

  // ========================================================================
  // One-shot retriggered by every edge of the watched clock
  always_comb begin
    next_r = r;
    next_r.s1 = system_clock_mon;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.timeout = 1'b0;
    // Edge compare uses only settled stages, never the first flop
    if (!enable || (r.s2 != r.s3)) begin
      next_r.cnt = '0;
    end else if (r.cnt == TIMEOUT_CYC - 1'b1) begin
      next_r.timeout = 1'b1;
      next_r.cnt = '0;
    end else begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign timeout = r.timeout;

endmodule

`default_nettype wire

// *** rtl/rsc_top.sv ***
// Reset source controller: sequences power-on, supply, pin, clock-loss,
// comparator, watchdog, memory-error and software resets, records the
// cause, and holds the power mode byte; registers sit on AXI4-Lite.
// Assumes asynchronous pin and analog inputs, same-clock event pulses.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"

module rsc_top #(
  parameter logic [`RSC_CNT_W-1:0] POR_DELAY_CYC   = `RSC_CNT_W'(`RSC_POR_DELAY_NS / `RSC_CLK_PERIOD_NS),
  parameter logic [`RSC_CNT_W-1:0] MCD_TIMEOUT_CYC = `RSC_CNT_W'(`RSC_MCD_TIMEOUT_NS / `RSC_CLK_PERIOD_NS)
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clk_en,
  input  wire logic [`RSC_AW-1:0] s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [`RSC_AW-1:0] s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               reset_pin_level,
  output logic                    reset_pin_drive,
  output logic                    reset_pin_oe_n,
  input  wire logic               supply_ok,
  input  wire logic               cmp_below,
  input  wire logic               system_clock_mon,
  input  wire logic               wdt_overflow,
  input  wire logic               mem_error,
  input  wire logic               wake_irq,
  output logic                    core_reset,
  output logic                    core_start,
  output logic                    core_clk_en,
  output logic                    osc_enable,
  output logic                    osc_internal,
  output logic [15:0]             fetch_addr,
  output logic                    wdt_restart,
  output logic                    wdt_tick,
  output logic [7:0]              port_latch,
  output logic                    port_open_drain,
  output logic                    port_pullup
);

  // ========================================================================
  // Helpers

  // Byte address of a register index
  function automatic logic [`RSC_AW-1:0] rsc_addr(input logic [7:0] idx);
    rsc_addr = {2'h0, idx, 2'h0};
  endfunction

  // Cause vector with a single source bit set
  function automatic logic [`RSC_NSRC-1:0] rsc_bit(input int b);
    logic [`RSC_NSRC-1:0] v;
    v = '0;
    v[b] = 1'b1;
    rsc_bit = v;
  endfunction

  // True for any mapped register
  function automatic logic rsc_hit(input logic [`RSC_AW-1:0] a);
    rsc_hit = (a == rsc_addr(`RSC_IDX_PWR)) ||
              (a == rsc_addr(`RSC_IDX_CAUSE)) ||
              (a == rsc_addr(`RSC_IDX_STAT));
  endfunction

  // ========================================================================
  // State and combinational terms

  rsc_pkg::rsc_regs_t   r;
  rsc_pkg::rsc_regs_t   next_r;
  logic                 mcd_timeout;
  logic                 do_wr;
  logic                 wr_pwr;
  logic                 wr_cause;
  logic                 sw_req;
  logic                 enter;
  logic                 go_run;
  logic [`RSC_NSRC-1:0] cause;

  // Clock-loss one-shot; only its pulse reaches the sequencer
  rsc_mcd #(
    .TIMEOUT_CYC (MCD_TIMEOUT_CYC)
  ) u_mcd (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .clk_en      (clk_en),
    .enable      (r.mcd_en),
    .system_clock_mon  (system_clock_mon),
    .timeout     (mcd_timeout)
  );

  // ========================================================================
  // Next-state logic
  always_comb begin
    next_r = r;
    enter = 1'b0;
    go_run = 1'b0;
    cause = '0;

    // Two-flop synchronisers for the pin and the analog levels
    next_r.pin1 = reset_pin_level;
    next_r.pin2 = r.pin1;
    next_r.sup1 = supply_ok;
    next_r.sup2 = r.sup1;
    next_r.cmp1 = cmp_below;
    next_r.cmp2 = r.cmp1;

    // One-cycle strobes
    next_r.core_start = 1'b0;
    next_r.wdt_restart = 1'b0;
    next_r.wdt_tick = 1'b0;

    // Write address and data are taken in either order
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_ok = 1'b1;
      next_r.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_ok = 1'b1;
      next_r.w_d = s_axi_wdata[7:0];
      next_r.w_s = s_axi_wstrb[0];
    end
    if (s_axi_bready && r.bvalid) begin
      next_r.bvalid = 1'b0;
    end
    do_wr = r.aw_ok && r.w_ok && !r.bvalid;
    if (do_wr) begin
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = rsc_hit(r.aw_a) ? `RSC_RESP_OK : `RSC_RESP_ERR;
    end
    wr_pwr = do_wr && r.w_s && (r.aw_a == rsc_addr(`RSC_IDX_PWR));
    wr_cause = do_wr && r.w_s && (r.aw_a == rsc_addr(`RSC_IDX_CAUSE));

    // Reads answer one cycle after the address is taken
    if (s_axi_rready && r.rvalid) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `RSC_RESP_OK;
      if (s_axi_araddr == rsc_addr(`RSC_IDX_PWR)) begin
        next_r.rdata = {r.gf, 2'h0};
      end else if (s_axi_araddr == rsc_addr(`RSC_IDX_CAUSE)) begin
        next_r.rdata = {1'b0, r.flags};
      end else if (s_axi_araddr == rsc_addr(`RSC_IDX_STAT)) begin
        next_r.rdata = {1'b0, !r.pin_oe_n, r.core_reset, r.stop,
                        r.idle, r.cmp_en, r.mcd_en, r.vmon_en};
      end else begin
        next_r.rdata = '0;
        next_r.rresp = `RSC_RESP_ERR;
      end
    end

    // An enabled interrupt ends idle; a write in the same cycle wins
    if (wake_irq) begin
      next_r.idle = 1'b0;
    end

    // Power mode byte; mode bits act only while the core runs
    if (wr_pwr) begin
      next_r.gf = r.w_d[`RSC_B_GF_HI:`RSC_B_GF_LO];
      if (r.w_d[`RSC_B_IDLE] && (r.st == rsc_pkg::RSC_RUN)) begin
        next_r.idle = 1'b1;
      end
      if (r.w_d[`RSC_B_STOP] && (r.st == rsc_pkg::RSC_RUN)) begin
        next_r.stop = 1'b1;
      end
    end

    // Enables live apart from the cause flags read back
    if (wr_cause) begin
      if (r.w_d[`RSC_B_POR]) begin
        next_r.vmon_en = 1'b1;
      end
      next_r.mcd_en = r.w_d[`RSC_B_MCD];
      next_r.cmp_en = r.w_d[`RSC_B_CMP];
    end
    sw_req = wr_cause && r.w_d[`RSC_B_SW] && (r.st == rsc_pkg::RSC_RUN);

    // Sequencer
    case (r.st)
      rsc_pkg::RSC_POR: begin
        next_r.src = rsc_bit(`RSC_B_POR);
        if (r.sup2) begin
          next_r.st = rsc_pkg::RSC_REL;
          next_r.cnt = POR_DELAY_CYC - 1'b1;
        end
      end
      rsc_pkg::RSC_VMON: begin
        if (r.sup2) begin
          next_r.st = rsc_pkg::RSC_REL;
          next_r.cnt = '0;
        end
      end
      rsc_pkg::RSC_REL: begin
        // Pin driven through the delay, then released; exit waits for it to rise
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - 1'b1;
        end else if (!r.pin_oe_n) begin
          next_r.pin_oe_n = 1'b1;
        end else if (r.pin2) begin
          go_run = 1'b1;
        end
      end
      rsc_pkg::RSC_HOLD: begin
        if (r.src[`RSC_B_PIN] ? r.pin2 : !r.cmp2) begin
          go_run = 1'b1;
        end
      end
      rsc_pkg::RSC_PULSE: begin
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - 1'b1;
        end else begin
          go_run = 1'b1;
        end
      end
      rsc_pkg::RSC_RUN: begin
        // Fixed priority when several sources fire together
        if (!r.pin2) begin
          enter = 1'b1;
          cause = rsc_bit(`RSC_B_PIN);
          next_r.st = rsc_pkg::RSC_HOLD;
        end else if (mcd_timeout) begin
          enter = 1'b1;
          cause = rsc_bit(`RSC_B_MCD);
          next_r.st = rsc_pkg::RSC_PULSE;
        end else if (r.cmp_en && r.cmp2) begin
          enter = 1'b1;
          cause = rsc_bit(`RSC_B_CMP);
          next_r.st = rsc_pkg::RSC_HOLD;
        end else if (wdt_overflow) begin
          enter = 1'b1;
          cause = rsc_bit(`RSC_B_WDT);
          next_r.st = rsc_pkg::RSC_PULSE;
        end else if (mem_error) begin
          enter = 1'b1;
          cause = rsc_bit(`RSC_B_MEM);
          next_r.st = rsc_pkg::RSC_PULSE;
        end else if (sw_req) begin
          enter = 1'b1;
          cause = rsc_bit(`RSC_B_SW);
          next_r.st = rsc_pkg::RSC_PULSE;
        end
      end
      default: begin
        next_r.st = rsc_pkg::RSC_POR;
        next_r.core_reset = 1'b1;
        next_r.pin_oe_n = 1'b0;
      end
    endcase

    // Enabled supply drop pre-empts every state but power-up and supply hold
    if (r.vmon_en && !r.sup2 &&
        (r.st != rsc_pkg::RSC_POR) && (r.st != rsc_pkg::RSC_VMON)) begin
      enter = 1'b1;
      go_run = 1'b0;
      cause = rsc_bit(`RSC_B_POR);
      next_r.st = rsc_pkg::RSC_VMON;
      next_r.pin_oe_n = 1'b0;
    end

    // Entry: halt core, power mode byte to reset values, ports to default
    if (enter) begin
      next_r.src = cause;
      next_r.cnt = `RSC_PULSE_CYC - 1'b1;
      next_r.core_reset = 1'b1;
      next_r.gf = '0;
      next_r.idle = 1'b0;
      next_r.stop = 1'b0;
      next_r.port_latch = `RSC_PORT_RST;
      next_r.port_open_drain = 1'b1;
      next_r.port_pullup = 1'b1;
    end

    // Exit: flags show only this cause, core fetches from the start
    if (go_run) begin
      next_r.st = rsc_pkg::RSC_RUN;
      next_r.flags = r.src;
      next_r.core_reset = 1'b0;
      next_r.core_start = 1'b1;
      next_r.osc_internal = 1'b1;
      next_r.fetch_addr = `RSC_FETCH_RST;
      next_r.wdt_restart = 1'b1;
    end

    // Watchdog time base; held at zero in reset and stop
    if ((r.st == rsc_pkg::RSC_RUN) && !r.stop) begin
      if (r.div == `RSC_WDT_DIV - 4'h1) begin
        next_r.div = '0;
        next_r.wdt_tick = 1'b1;
      end else begin
        next_r.div = r.div + 4'h1;
      end
    end else begin
      next_r.div = '0;
    end

    // Clock gates follow the mode bits
    next_r.core_clk_en = !next_r.core_reset && !next_r.idle && !next_r.stop;
    next_r.osc_enable = !next_r.stop;

    // Ready terms registered so the ports come straight from flops
    next_r.awready = !next_r.aw_ok && !next_r.bvalid;
    next_r.wready = !next_r.w_ok && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
  end

  // ========================================================================
  // State register; power-on clears the source enables and sets osc_enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= rsc_pkg::RSC_POR;
      r.core_reset <= 1'b1;
      r.osc_enable <= 1'b1;
      r.osc_internal <= 1'b1;
      r.port_latch <= `RSC_PORT_RST;
      r.port_open_drain <= 1'b1;
      r.port_pullup <= 1'b1;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ========================================================================
  // Outputs
  assign s_axi_awready   = r.awready;
  assign s_axi_wready    = r.wready;
  assign s_axi_bvalid    = r.bvalid;
  assign s_axi_bresp     = r.bresp;
  assign s_axi_arready   = r.arready;
  assign s_axi_rvalid    = r.rvalid;
  assign s_axi_rresp     = r.rresp;
  assign s_axi_rdata     = {24'h00_0000, r.rdata};
  assign reset_pin_drive = r.pin_drive;
  assign reset_pin_oe_n  = r.pin_oe_n;
  assign core_reset      = r.core_reset;
  assign core_start      = r.core_start;
  assign core_clk_en     = r.core_clk_en;
  assign osc_enable      = r.osc_enable;
  assign osc_internal    = r.osc_internal;
  assign fetch_addr      = r.fetch_addr;
  assign wdt_restart     = r.wdt_restart;
  assign wdt_tick        = r.wdt_tick;
  assign port_latch      = r.port_latch;
  assign port_open_drain = r.port_open_drain;
  assign port_pullup     = r.port_pullup;

endmodule

`default_nettype wire

// *** testbench/rsc_far.sv ***
// Far-side model: reset pin wire with pull-up, external reset switch, watched clock.
// Assumes the bench supplies aclk and drives the switch and halt inputs.
`timescale 1ns/1ps
`default_nettype none
module rsc_far (
  input  wire logic aclk,
  input  wire logic oe_n,
  input  wire logic ext_low,
  input  wire logic mon_halt,
  output logic      pin_level,
  output logic      mon_clk
);
  // ==========================================================================
  // Pin and clock
  logic [1:0] div = 2'h0;
  // Wired-AND pin; the pull-up wins only when nobody pulls low
  assign pin_level = oe_n & ~ext_low;
  // Watched clock at a quarter of aclk; halting it starves the detector
  always @(posedge aclk) begin
    if (!mon_halt) begin
      div <= div + 2'h1;
    end
  end
  assign mon_clk = div[1];
endmodule
`default_nettype wire

// *** testbench/rsc_assertions.sv ***
// Port checker of the reset source controller.
// Assumes a bind into rsc_top; it sees that module's ports only.
`timescale 1ns/1ps
`default_nettype none
module rsc_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        reset_pin_level,
  input wire logic        reset_pin_drive,
  input wire logic        reset_pin_oe_n,
  input wire logic        wdt_overflow,
  input wire logic        mem_error,
  input wire logic        core_reset,
  input wire logic        core_start,
  input wire logic        core_clk_en,
  input wire logic        osc_enable,
  input wire logic        osc_internal,
  input wire logic [15:0] fetch_addr,
  input wire logic        wdt_tick,
  input wire logic        wdt_restart,
  input wire logic [7:0]  port_latch,
  input wire logic        port_open_drain,
  input wire logic        port_pullup
);
  // ==========================================================================
  // Checks; one clock, silent while reset is low
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_port_safe: assert property (core_reset |-> port_latch == 8'hFF && port_open_drain && port_pullup)
    else $error("port state wrong in reset");
  a_reset_halts: assert property (core_reset |-> !core_clk_en)
    else $error("core clocked in reset");
  a_stop_osc: assert property (!osc_enable |-> !core_clk_en)
    else $error("core clocked with oscillator off");
  a_pin_drive: assert property (!reset_pin_oe_n |-> core_reset && !reset_pin_drive)
    else $error("pin driven outside reset");
  a_exit_fetch: assert property (core_start |-> fetch_addr == 16'h0000 && osc_internal && osc_enable)
    else $error("exit state wrong");
  a_start_pulse: assert property (core_start |=> !core_start)
    else $error("start pulse too long");
  a_wdt_restart: assert property (wdt_restart == core_start)
    else $error("watchdog restart not at exit");
  a_tick_gap: assert property (wdt_tick |=> !wdt_tick [*8])
    else $error("watchdog tick too close");
  a_wdt_reset: assert property (wdt_overflow && !core_reset |-> ##[1:3] core_reset)
    else $error("no watchdog reset");
  a_mem_reset: assert property (mem_error && !core_reset |-> ##[1:3] core_reset)
    else $error("no memory error reset");
  a_pin_reset: assert property (!reset_pin_level [*4] |=> core_reset)
    else $error("low pin ignored");
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench of the reset source controller with a small model.
// Assumes the design, the far-side model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"
module tb_top;
  // ==========================================================================
  // Signals and model state
  logic        aclk = '0, aresetn = '0, clk_en = '1, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0, supply_ok = '0, cmp_below = '0, wdt_overflow = '0;
  logic        mem_error = '0, wake_irq = '0, ext_low = '0, mon_halt = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, br;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reset_pin_level;
  logic        reset_pin_drive, reset_pin_oe_n, system_clock_mon, core_reset, core_start, core_clk_en, osc_enable;
  logic        osc_internal, wdt_restart, wdt_tick, port_open_drain, port_pullup;
  logic [15:0] fetch_addr;
  logic [7:0]  port_latch;
  int          bad_count = 0, n_compared = 0, seed = 90225, k, m_cause, m_gf, m_en;
  localparam logic [11:0] PWR = 12'(`RSC_IDX_PWR * 4), CAUSE = 12'(`RSC_IDX_CAUSE * 4), STAT = 12'(`RSC_IDX_STAT * 4);

  always #2 aclk = ~aclk;
  rsc_top #(.POR_DELAY_CYC(17'h0_0014), .MCD_TIMEOUT_CYC(17'h0_0028)) i_dut (.aclk, .aresetn, .clk_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_level, .reset_pin_drive, .reset_pin_oe_n, .supply_ok,
    .cmp_below, .system_clock_mon, .wdt_overflow, .mem_error, .wake_irq, .core_reset, .core_start, .core_clk_en,
    .osc_enable, .osc_internal, .fetch_addr, .wdt_restart, .wdt_tick, .port_latch, .port_open_drain, .port_pullup);
  rsc_far i_far (.aclk, .oe_n(reset_pin_oe_n), .ext_low, .mon_halt, .pin_level(reset_pin_level), .mon_clk(system_clock_mon));

  // ==========================================================================
  // Compare, bus and wait helpers
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Bounded wait for the core reset level; the count is kept for timing checks
  task wait_lvl(input logic v);
    k = 0;
    while (core_reset !== v && k < 400) begin
      @(posedge aclk);
      k++;
    end
    chk({31'h0, core_reset}, {31'h0, v});
  endtask
  // Model view after a reset: only the latest cause, storage bits cleared
  task m_rst(input int s);
    m_cause = 1 << s;
    m_gf = 0;
  endtask
  task chk_all(input string t);
    rd(CAUSE);
    chk(d, m_cause);
    rd(PWR);
    chk(d, m_gf << 2);
    rd(STAT);
    chk({29'h0, d[2:0]}, m_en);
    $display("test %s done", t);
  endtask
  task pulse(input int s);
    @(posedge aclk);
    if (s == 3) wdt_overflow <= 1'b1;
    if (s == 6) mem_error <= 1'b1;
    @(posedge aclk);
    wdt_overflow <= 1'b0;
    mem_error <= 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    supply_ok <= 1'b1;
    m_en = 0;
    m_rst(1);
    wait_lvl(1'b0);
    chk(32'(k > 20), 32'h1);
    chk_all("power-up");
    wr(PWR, 8'hFD);
    m_gf = 63;
    repeat (3) @(posedge aclk);
    chk({30'h0, core_clk_en, osc_enable}, 32'h1);
    wake_irq <= 1'b1;
    @(posedge aclk);
    wake_irq <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({31'h0, core_clk_en}, 32'h1);
    chk_all("idle");
    for (int i = 0; i < 4; i++) begin
      m_gf = $random(seed) & 63;
      wr(PWR, 8'(m_gf << 2));
      chk_all("storage");
    end
    wr(PWR, 8'h02);
    repeat (3) @(posedge aclk);
    chk({30'h0, core_clk_en, osc_enable}, 32'h0);
    ext_low <= 1'b1;
    wait_lvl(1'b1);
    ext_low <= 1'b0;
    m_rst(0);
    wait_lvl(1'b0);
    chk({osc_internal, osc_enable, 14'h0, fetch_addr}, 32'hC000_0000);
    chk_all("pin");
    for (int s = 3; s <= 6; s++) begin
      if (s == 5) continue;
      if (s == 4) wr(CAUSE, 8'h10);
      else pulse(s);
      wait_lvl(1'b1);
      m_rst(s);
      wait_lvl(1'b0);
      chk_all("event");
    end
    wr(CAUSE, 8'h04);
    m_en = 2;
    mon_halt <= 1'b1;
    wait_lvl(1'b1);
    mon_halt <= 1'b0;
    m_rst(2);
    wait_lvl(1'b0);
    chk_all("clock loss");
    wr(CAUSE, 8'h20); // comparator settled low beforehand
    m_en = 4;
    cmp_below <= 1'b1;
    wait_lvl(1'b1);
    repeat (10) @(posedge aclk);
    cmp_below <= 1'b0;
    m_rst(5);
    wait_lvl(1'b0);
    chk_all("comparator");
    wr(CAUSE, 8'h02);
    m_en = 1;
    chk_all("monitor on");
    supply_ok <= 1'b0;
    wait_lvl(1'b1);
    repeat (3) @(posedge aclk);
    chk({31'h0, reset_pin_oe_n}, 32'h0);
    supply_ok <= 1'b1;
    m_rst(1);
    wait_lvl(1'b0);
    chk(32'(k < 16), 32'h1);
    chk_all("supply drop");
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    m_en = 0;
    wait_lvl(1'b0);
    chk_all("second power-on");
    rd(12'h004);
    chk({28'h0, r, d[1:0]}, 32'h8);
    wr(12'h004, 8'h5A);
    chk({30'h0, br}, 32'h2);
    results();
  end

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    bad_count++;
    results();
  end

  task results();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
endmodule
bind rsc_top rsc_assertions i_chk (.aclk, .aresetn, .reset_pin_level, .reset_pin_drive, .reset_pin_oe_n,
  .wdt_overflow, .mem_error, .core_reset, .core_start, .core_clk_en, .osc_enable, .osc_internal, .fetch_addr,
  .wdt_tick, .wdt_restart, .port_latch, .port_open_drain, .port_pullup);
`default_nettype wire
